/* hdl/ptg_consts.vh */
// register map, reset values and timing constants of the test pattern generator
`ifndef PTG_CONSTS_VH
`define PTG_CONSTS_VH
// ----------------------------------------------------------------------------
// register offsets (indirect page 0)
// ----------------------------------------------------------------------------
`define PTG_A_CTRL      5'h01
`define PTG_A_CFG       5'h02
`define PTG_A_PKTID     5'h03
`define PTG_A_LLEN_H    5'h04
`define PTG_A_LLEN_L    5'h05
`define PTG_A_BARW_H    5'h06
`define PTG_A_BARW_L    5'h07
`define PTG_A_AROW_H    5'h08
`define PTG_A_AROW_L    5'h09
`define PTG_A_TROW_H    5'h0a
`define PTG_A_TROW_L    5'h0b
`define PTG_A_LINT_H    5'h0c
`define PTG_A_LINT_L    5'h0d
`define PTG_A_TOPB      5'h0e
`define PTG_A_BOTB      5'h0f
`define PTG_A_FILL0     5'h10
`define PTG_A_FILL1     5'h11
`define PTG_A_FILL2     5'h12
`define PTG_A_FILL3     5'h13
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PTG_F_ON        0
`define PTG_F_FIXED     7
`define PTG_F_BARS_HI   5
`define PTG_F_BARS_LO   4
`define PTG_F_BLK_HI    3
`define PTG_F_BLK_LO    0
`define PTG_F_VC_HI     7
`define PTG_F_VC_LO     6
`define PTG_F_DT_HI     5
`define PTG_F_DT_LO     0
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PTG_R_CTRL      8'h00
`define PTG_R_CFG       8'h33
`define PTG_R_PKTID     8'h24
`define PTG_R_LLEN_H    8'h07
`define PTG_R_LLEN_L    8'h80
`define PTG_R_BARW_H    8'h00
`define PTG_R_BARW_L    8'hf0
`define PTG_R_AROW_H    8'h01
`define PTG_R_AROW_L    8'he0
`define PTG_R_TROW_H    8'h02
`define PTG_R_TROW_L    8'h0d
`define PTG_R_LINT_H    8'h0c
`define PTG_R_LINT_L    8'h67
`define PTG_R_TOPB      8'h21
`define PTG_R_BOTB      8'h0a
`define PTG_R_FILL0     8'haa
`define PTG_R_FILL1     8'h33
`define PTG_R_FILL2     8'hf0
`define PTG_R_FILL3     8'h7f
// ----------------------------------------------------------------------------
// lane rate codes and interval unit lengths in picoseconds
// ----------------------------------------------------------------------------
`define PTG_RATE_400M   2'h0
`define PTG_RATE_800M   2'h1
`define PTG_RATE_1G2    2'h2
`define PTG_RATE_1G6    2'h3
`define PTG_UNIT_10NS_PS   10000
`define PTG_UNIT_13NS_PS   13330
`define PTG_UNIT_20NS_PS   20000
`define PTG_CLK_PS         100000
// packet type codes for frame start, frame end
`define PTG_DT_FS       6'h00
`define PTG_DT_FE       6'h01
`define PTG_FIFO_DEPTH  32
`define PTG_FIFO_AW     5
`endif

/* hdl/ptg_fifo.v */
// synchronous valid/ready fifo with registered read data
module ptg_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             i_clk,     // clock
    input  wire             i_nrst,    // sync reset, low
    input  wire [WIDTH-1:0] i_data,    // write data
    input  wire             i_valid,   // write request
    output wire             o_ready,   // space available
    output reg  [WIDTH-1:0] o_data,    // read data
    output reg              o_valid,   // read data valid
    input  wire             i_ready    // consumer takes data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0]      wp_q;
    reg [AW:0]      rp_q;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    assign full    = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty   = (wp_q == rp_q);
    assign o_ready = ~full;
    assign push    = i_valid & ~full;
    // refill the output register when empty or being consumed
    assign pop     = ~empty & (~o_valid | i_ready);

    always @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wp_q[AW-1:0]] <= i_data;
        end
    end

    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            wp_q    <= {(AW+1){1'b0}};
            rp_q    <= {(AW+1){1'b0}};
            o_valid <= 1'b0;
            o_data  <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
            begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop)
            begin
                rp_q    <= rp_q + 1'b1;
                o_data  <= mem_q[rp_q[AW-1:0]];
                o_valid <= 1'b1;
            end
            else if (i_ready)
            begin
                o_valid <= 1'b0;
            end
        end
    end
endmodule // ptg_fifo

/* hdl/ptg_core.v */
// test pattern generator: register file, frame timing and packet stream
`include "ptg_consts.vh"

// Overview of operation
// - fixed-select bit 0 sends color bars, 1 sends fixed block; resets 0.
// - bar count code 00,01,10,11 gives 1,2,4,8 bars; reset 3.
// - block size 1..15 bytes sets fixed block length; reset 3.
// - six-bit data type goes into each long packet; reset RGB888 code.
// - active line bytes is 16 bits over high and low registers.
// - bar width in bytes applies to all bars except the last.
// - last bar fills the remaining bytes of the active line.
// - active rows per frame is 16 bits, reset 480.
// - total rows per frame including blanking is 16 bits, reset 0x020d.
// - line interval is 16 bits; lines start one interval apart.
// - at 800 Mbps or 1.6 Gbps one interval count is 10 ns.
// - at 1.2 Gbps one interval count is 13.33 ns.
// - at 400 Mbps one interval count is 20 ns.
// - frames start only while generator on bit is 1, a running frame completes; resets off.
// - bar n uses fill byte n mod 4, so bars 4..7 reuse fill0..fill3; fixed block cycles fill bytes.
// - top blank rows sit between frame start and first video line.
// - bottom blank rows sit between last video line and frame end.
module ptg_core (
    input  wire       i_clk,        // 10 MHz clock
    input  wire       i_nrst,       // sync reset, low
    input  wire [1:0] i_lane_rate,  // lane rate code, from another domain
    input  wire [4:0] i_reg_addr,   // indirect register offset
    input  wire [7:0] i_reg_wdata,  // write data
    input  wire       i_reg_wr,     // write strobe
    input  wire       i_reg_rd,     // read strobe
    output reg  [7:0] o_reg_rdata,  // read data, one cycle after strobe
    output reg        o_busy,       // frame in progress
    output reg  [1:0] o_pkt_vc,     // virtual channel of current packet
    output reg  [5:0] o_pkt_dt,     // data type of current packet
    output reg        o_pkt_short,  // 1: short packet (fs/fe)
    output reg        o_pkt_sof,    // first byte / short packet
    output reg        o_pkt_eof,    // last byte of packet
    output reg  [7:0] o_pkt_data,   // payload byte
    output reg        o_pkt_valid,  // stream valid
    input  wire       i_pkt_ready   // stream ready from transmit path
);
    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg [7:0] ctrl_q, cfg_q, pktid_q;
    reg [7:0] llen_h_q, llen_l_q, barw_h_q, barw_l_q;
    reg [7:0] arow_h_q, arow_l_q, trow_h_q, trow_l_q;
    reg [7:0] lint_h_q, lint_l_q, topb_q, botb_q;
    reg [7:0] fill0_q, fill1_q, fill2_q, fill3_q;
    reg [7:0] rd_d;

    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            ctrl_q   <= `PTG_R_CTRL;
            // fixed select, bar code and block size reset
            cfg_q    <= `PTG_R_CFG;
            // vc 0 and data type reset
            pktid_q  <= `PTG_R_PKTID;
            llen_h_q <= `PTG_R_LLEN_H;
            llen_l_q <= `PTG_R_LLEN_L;
            barw_h_q <= `PTG_R_BARW_H;
            barw_l_q <= `PTG_R_BARW_L;
            arow_h_q <= `PTG_R_AROW_H;
            arow_l_q <= `PTG_R_AROW_L;
            trow_h_q <= `PTG_R_TROW_H;
            trow_l_q <= `PTG_R_TROW_L;
            lint_h_q <= `PTG_R_LINT_H;
            lint_l_q <= `PTG_R_LINT_L;
            topb_q   <= `PTG_R_TOPB;
            botb_q   <= `PTG_R_BOTB;
            fill0_q  <= `PTG_R_FILL0;
            fill1_q  <= `PTG_R_FILL1;
            fill2_q  <= `PTG_R_FILL2;
            fill3_q  <= `PTG_R_FILL3;
        end
        else if (i_reg_wr)
        begin
            case (i_reg_addr)
                `PTG_A_CTRL:   ctrl_q   <= {7'h00, i_reg_wdata[`PTG_F_ON]};
                // reserved bit 6 stays zero
                `PTG_A_CFG:    cfg_q    <= {i_reg_wdata[7], 1'b0, i_reg_wdata[5:0]};
                `PTG_A_PKTID:  pktid_q  <= i_reg_wdata;
                `PTG_A_LLEN_H: llen_h_q <= i_reg_wdata;
                `PTG_A_LLEN_L: llen_l_q <= i_reg_wdata;
                `PTG_A_BARW_H: barw_h_q <= i_reg_wdata;
                `PTG_A_BARW_L: barw_l_q <= i_reg_wdata;
                `PTG_A_AROW_H: arow_h_q <= i_reg_wdata;
                `PTG_A_AROW_L: arow_l_q <= i_reg_wdata;
                `PTG_A_TROW_H: trow_h_q <= i_reg_wdata;
                `PTG_A_TROW_L: trow_l_q <= i_reg_wdata;
                `PTG_A_LINT_H: lint_h_q <= i_reg_wdata;
                `PTG_A_LINT_L: lint_l_q <= i_reg_wdata;
                `PTG_A_TOPB:   topb_q   <= i_reg_wdata;
                `PTG_A_BOTB:   botb_q   <= i_reg_wdata;
                `PTG_A_FILL0:  fill0_q  <= i_reg_wdata;
                `PTG_A_FILL1:  fill1_q  <= i_reg_wdata;
                `PTG_A_FILL2:  fill2_q  <= i_reg_wdata;
                `PTG_A_FILL3:  fill3_q  <= i_reg_wdata;
                default:       ctrl_q   <= ctrl_q;
            endcase
        end
    end

    always @*
    begin
        case (i_reg_addr)
            `PTG_A_CTRL:   rd_d = ctrl_q;
            `PTG_A_CFG:    rd_d = cfg_q;
            `PTG_A_PKTID:  rd_d = pktid_q;
            `PTG_A_LLEN_H: rd_d = llen_h_q;
            `PTG_A_LLEN_L: rd_d = llen_l_q;
            `PTG_A_BARW_H: rd_d = barw_h_q;
            `PTG_A_BARW_L: rd_d = barw_l_q;
            `PTG_A_AROW_H: rd_d = arow_h_q;
            `PTG_A_AROW_L: rd_d = arow_l_q;
            `PTG_A_TROW_H: rd_d = trow_h_q;
            `PTG_A_TROW_L: rd_d = trow_l_q;
            `PTG_A_LINT_H: rd_d = lint_h_q;
            `PTG_A_LINT_L: rd_d = lint_l_q;
            `PTG_A_TOPB:   rd_d = topb_q;
            `PTG_A_BOTB:   rd_d = botb_q;
            `PTG_A_FILL0:  rd_d = fill0_q;
            `PTG_A_FILL1:  rd_d = fill1_q;
            `PTG_A_FILL2:  rd_d = fill2_q;
            `PTG_A_FILL3:  rd_d = fill3_q;
            default:       rd_d = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------------------
    wire        gen_on     = ctrl_q[`PTG_F_ON];
    wire        fixed_sel  = cfg_q[`PTG_F_FIXED];
    wire [1:0]  bar_code   = cfg_q[`PTG_F_BARS_HI:`PTG_F_BARS_LO];
    wire [3:0]  blk_size   = cfg_q[`PTG_F_BLK_HI:`PTG_F_BLK_LO];
    wire [1:0]  vc_val     = pktid_q[`PTG_F_VC_HI:`PTG_F_VC_LO];
    wire [5:0]  dt_val     = pktid_q[`PTG_F_DT_HI:`PTG_F_DT_LO];
    // active line bytes from two registers
    wire [15:0] line_bytes = {llen_h_q, llen_l_q};
    wire [15:0] bar_bytes  = {barw_h_q, barw_l_q};
    wire [15:0] act_rows   = {arow_h_q, arow_l_q};
    wire [15:0] tot_rows   = {trow_h_q, trow_l_q};
    wire [15:0] int_count  = {lint_h_q, lint_l_q};
    wire [3:0]  bar_total  = 4'h1 << bar_code;

    // ------------------------------------------------------------------------
    // lane rate sync and interval unit
    // ------------------------------------------------------------------------
    reg  [1:0]  rate_s1_q, rate_s2_q;
    reg  [16:0] acc_q;
    reg  [16:0] unit_ps;
    reg         unit_tick;
    wire [16:0] acc_sum;

    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            rate_s1_q <= 2'h0;
            rate_s2_q <= 2'h0;
        end
        else
        begin
            rate_s1_q <= i_lane_rate;
            rate_s2_q <= rate_s1_q;
        end
    end

    always @*
    begin
        case (rate_s2_q)
            `PTG_RATE_800M, `PTG_RATE_1G6: unit_ps = 17'd`PTG_UNIT_10NS_PS;
            `PTG_RATE_1G2:                 unit_ps = 17'd`PTG_UNIT_13NS_PS;
            default:                       unit_ps = 17'd`PTG_UNIT_20NS_PS;
        endcase
    end

    // phase accumulator: count units elapsed per clock; a clock covers several
    // units, so the interval counter steps by the whole count per clock
    reg  [3:0]  steps;
    reg  [16:0] rem;
    reg         line_start;
    reg  [19:0] unit_acc_q;
    reg  [19:0] unit_target;
    wire [19:0] unit_next;

    always @*
    begin
        steps = 4'h0;
        rem   = acc_q + 17'd`PTG_CLK_PS;
        while_blk_dummy(rem, unit_ps, steps, rem);
    end

    task while_blk_dummy;
        input  [16:0] a;
        input  [16:0] u;
        output [3:0]  n;
        output [16:0] r;
        integer k;
        begin
            n = 4'h0;
            r = a;
            for (k = 0; k < 11; k = k + 1)
            begin
                if (r >= u)
                begin
                    r = r - u;
                    n = n + 4'h1;
                end
            end
        end
    endtask

    assign acc_sum   = rem;
    assign unit_next = unit_acc_q + {16'h0000, steps};

    always @*
    begin
        unit_target = {4'h0, int_count};
        line_start  = (unit_next >= unit_target);
        unit_tick   = line_start;
    end

    // ------------------------------------------------------------------------
    // frame timing
    // ------------------------------------------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_FS   = 3'h1;
    localparam S_WAIT = 3'h2;
    localparam S_HDR  = 3'h3;
    localparam S_DATA = 3'h4;
    localparam S_FE   = 3'h5;

    reg [2:0]  st_q;
    reg [15:0] row_q;
    reg [15:0] byte_q;
    reg [15:0] in_bar_q;
    reg [2:0]  bar_q;
    reg [3:0]  blk_q;
    reg [1:0]  fidx_q;
    reg        run_q;

    // push side into the fifo: {short,sof,eof,dt,vc,data}
    reg        f_valid;
    reg [18:0] f_data;
    wire       f_ready;
    wire [18:0] q_data;
    wire        q_valid;

    wire [15:0] vid_first = {8'h00, topb_q};
    wire [15:0] vid_end   = vid_first + act_rows;
    wire [15:0] fe_row    = vid_end + {8'h00, botb_q};
    reg  [7:0]  fill_b;

    always @*
    begin
        case (fidx_q)
            2'h0:    fill_b = fill0_q;
            2'h1:    fill_b = fill1_q;
            2'h2:    fill_b = fill2_q;
            default: fill_b = fill3_q;
        endcase
    end

    wire last_byte = (byte_q == line_bytes - 16'h0001);
    // non-final bars are bar width long; final takes the rest
    wire bar_done  = (in_bar_q == bar_bytes - 16'h0001) && (bar_q != bar_total - 4'h1);

    always @*
    begin
        f_valid = 1'b0;
        f_data  = 19'h00000;
        case (st_q)
            S_FS:
            begin
                f_valid = 1'b1;
                f_data  = {1'b1, 1'b1, 1'b1, `PTG_DT_FS, vc_val, 8'h00};
            end
            // frame end only after the bottom blank rows
            S_FE:
            begin
                f_valid = 1'b1;
                f_data  = {1'b1, 1'b1, 1'b1, `PTG_DT_FE, vc_val, 8'h00};
            end
            S_DATA:
            begin
                f_valid = 1'b1;
                // vc and data type in each long packet
                // byte from the current bar or block fill register
                f_data  = {1'b0, (byte_q == 16'h0000), last_byte, dt_val, vc_val, fill_b};
            end
            default:
            begin
                f_valid = 1'b0;
                f_data  = 19'h00000;
            end
        endcase
    end

    wire adv = f_valid & f_ready;

    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            st_q       <= S_IDLE;
            row_q      <= 16'h0000;
            byte_q     <= 16'h0000;
            in_bar_q   <= 16'h0000;
            bar_q      <= 3'h0;
            blk_q      <= 4'h0;
            fidx_q     <= 2'h0;
            acc_q      <= 17'h00000;
            unit_acc_q <= 20'h00000;
            run_q      <= 1'b0;
        end
        else
        begin
            acc_q      <= acc_sum;
            // carry the units past the boundary so the mean interval stays exact
            unit_acc_q <= unit_tick ? (unit_next - unit_target) : unit_next;
            case (st_q)
                S_IDLE:
                begin
                    run_q <= 1'b0;
                    if (gen_on && unit_tick)
                    begin
                        st_q  <= S_FS;
                        row_q <= 16'h0000;
                        run_q <= 1'b1;
                    end
                end
                S_FS:
                begin
                    if (adv)
                    begin
                        st_q <= S_WAIT;
                    end
                end
                S_WAIT:
                begin
                    if (unit_tick)
                    begin
                        if (row_q + 16'h0001 >= tot_rows)
                        begin
                            st_q  <= gen_on ? S_FS : S_IDLE;
                            row_q <= 16'h0000;
                        end
                        else
                        begin
                            row_q <= row_q + 16'h0001;
                            if ((row_q + 16'h0001 >= vid_first) && (row_q + 16'h0001 < vid_end))
                            begin
                                st_q <= S_HDR;
                            end
                            else if (row_q + 16'h0001 == fe_row)
                            begin
                                st_q <= S_FE;
                            end
                        end
                    end
                end
                S_HDR:
                begin
                    byte_q   <= 16'h0000;
                    in_bar_q <= 16'h0000;
                    bar_q    <= 3'h0;
                    blk_q    <= 4'h0;
                    fidx_q   <= 2'h0;
                    st_q     <= (line_bytes == 16'h0000) ? S_WAIT : S_DATA;
                end
                S_DATA:
                begin
                    if (adv)
                    begin
                        byte_q <= byte_q + 16'h0001;
                        if (fixed_sel)
                        begin
                            // block of blk_size bytes, fill bytes in turn
                            if (blk_q + 4'h1 >= blk_size)
                            begin
                                blk_q  <= 4'h0;
                                fidx_q <= 2'h0;
                            end
                            else
                            begin
                                blk_q  <= blk_q + 4'h1;
                                fidx_q <= fidx_q + 2'h1;
                            end
                        end
                        // bar pattern when fixed select is 0
                        else if (bar_done)
                        begin
                            in_bar_q <= 16'h0000;
                            bar_q    <= bar_q + 3'h1;
                            fidx_q   <= bar_q[1:0] + 2'h1;
                        end
                        else
                        begin
                            in_bar_q <= in_bar_q + 16'h0001;
                        end
                        if (last_byte)
                        begin
                            st_q <= S_WAIT;
                        end
                    end
                end
                S_FE:
                begin
                    if (adv)
                    begin
                        st_q <= S_WAIT;
                    end
                end
                default:
                begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------------------
    // back-pressure from the transmit path stalls the byte walk above
    // the fifo may only advance when the output stage really loads its word
    wire out_take = i_pkt_ready | ~o_pkt_valid;

    ptg_fifo #(
        .WIDTH (19),
        .DEPTH (`PTG_FIFO_DEPTH),
        .AW    (`PTG_FIFO_AW)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_data  (f_data),
        .i_valid (f_valid),
        .o_ready (f_ready),
        .o_data  (q_data),
        .o_valid (q_valid),
        .i_ready (out_take)
    );

    always @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            o_reg_rdata <= 8'h00;
            o_busy      <= 1'b0;
            o_pkt_vc    <= 2'h0;
            o_pkt_dt    <= 6'h00;
            o_pkt_short <= 1'b0;
            o_pkt_sof   <= 1'b0;
            o_pkt_eof   <= 1'b0;
            o_pkt_data  <= 8'h00;
            o_pkt_valid <= 1'b0;
        end
        else
        begin
            if (i_reg_rd)
            begin
                o_reg_rdata <= rd_d;
            end
            o_busy <= run_q;
            if (out_take)
            begin
                o_pkt_valid <= q_valid;
                o_pkt_short <= q_data[18];
                o_pkt_sof   <= q_data[17];
                o_pkt_eof   <= q_data[16];
                o_pkt_dt    <= q_data[15:10];
                o_pkt_vc    <= q_data[9:8];
                o_pkt_data  <= q_data[7:0];
            end
        end
    end
endmodule // ptg_core

/* sim/ptg_core_assertions.sv */
// checker of the pattern generator stream and busy flag
module ptg_chk (
    input wire       i_clk, i_nrst, i_reg_wr, i_reg_rd, i_pkt_ready,
    input wire       o_busy, o_pkt_short, o_pkt_sof, o_pkt_eof, o_pkt_valid,
    input wire [1:0] i_lane_rate, o_pkt_vc,
    input wire [4:0] i_reg_addr,
    input wire [5:0] o_pkt_dt,
    input wire [7:0] i_reg_wdata, o_reg_rdata, o_pkt_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence stall; o_pkt_valid && !i_pkt_ready; endsequence
    sequence mid_pkt; o_pkt_valid && i_pkt_ready && !o_pkt_eof ##1 o_pkt_valid; endsequence
    sequence pkt_done; o_pkt_valid && i_pkt_ready && o_pkt_eof ##1 o_pkt_valid; endsequence
    a_beat_hold: assert property (stall |=> o_pkt_valid && $stable(o_pkt_data))
        else $error("stalled beat changed");
    a_short_whole: assert property (o_pkt_valid && o_pkt_short |-> o_pkt_sof && o_pkt_eof)
        else $error("short packet not single beat");
    a_short_type: assert property (o_pkt_valid && o_pkt_short |-> o_pkt_dt <= 6'h01)
        else $error("short packet type wrong");
    a_vc_steady: assert property (mid_pkt |-> $stable(o_pkt_vc))
        else $error("channel changed in packet");
    a_dt_steady: assert property (mid_pkt |-> $stable(o_pkt_dt))
        else $error("type changed in packet");
    a_sof_next: assert property (pkt_done |-> o_pkt_sof)
        else $error("packet start missing");
    a_valid_busy: assert property (o_pkt_valid |-> o_busy)
        else $error("output outside frame");
    a_reset_idle: assert property ($rose(i_nrst) |-> !o_pkt_valid && !o_busy)
        else $error("not idle after reset");
endmodule // ptg_chk
bind ptg_core ptg_chk ptg_chk_inst (.*);

/* sim/ptg_sink.sv */
// downstream receiver model: in slow mode it takes one beat in four
module ptg_sink (
    input  wire  i_clk,   // clock
    input  wire  i_slow,  // stall mode
    output logic o_ready  // accepts beat
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph_q = 2'h0;
    always @(posedge i_clk) ph_q <= ph_q + 2'h1;
    assign o_ready = !i_slow || ph_q == 2'h3;
endmodule // ptg_sink

/* sim/tb.sv */
// self-checking bench of the pattern generator core
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0, i_nrst = 0, i_reg_wr = 0, i_reg_rd = 0, slow = 1;
    logic o_busy, o_pkt_short, o_pkt_sof, o_pkt_eof, o_pkt_valid, i_pkt_ready;
    logic [4:0] i_reg_addr = 5'h00;
    logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata, o_pkt_data;
    logic [1:0] o_pkt_vc, rate = 2'h1;
    logic [5:0] o_pkt_dt;
    int num_errors = 0, n_checks = 0;
    logic [7:0] rv [0:19] = '{8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hf0, 8'h01,
        8'he0, 8'h02, 8'h0d, 8'h0c, 8'h67, 8'h21, 8'h0a, 8'haa, 8'h33, 8'hf0, 8'h7f};
    logic [7:0] cv [4:15] = '{8'h00, 8'h05, 8'h00, 8'h02, 8'h00, 8'h02, 8'h00, 8'h06,
        8'h01, 8'h00, 8'h01, 8'h01};
    logic [7:0] fill [0:2] = '{8'haa, 8'h33, 8'hf0};
    ptg_core ptg_core_inst (.i_clk, .i_nrst, .i_lane_rate(rate), .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_busy, .o_pkt_vc, .o_pkt_dt, .o_pkt_short,
        .o_pkt_sof, .o_pkt_eof, .o_pkt_data, .o_pkt_valid, .i_pkt_ready);
    ptg_sink ptg_sink_inst (.i_clk, .i_slow(slow), .o_ready(i_pkt_ready));
    initial forever #50 i_clk = ~i_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("errors=%0d checks=%0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
        @(posedge i_clk) #1 i_reg_wr = 0;
        @(posedge i_clk) #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        {i_reg_addr, i_reg_rd} = {a, 1'b1};
        @(posedge i_clk) #1 i_reg_rd = 0;
        @(posedge i_clk) #1 d = o_reg_rdata;
    endtask
    // waits for one taken beat, a stalled far side may hold it for a while
    task automatic beat(input logic [5:0] dt, input logic [2:0] fl, input logic [7:0] d);
        int n = 0;
        @(negedge i_clk);
        while ((o_pkt_valid !== 1'b1 || i_pkt_ready !== 1'b1) && n < 1000)
        begin
            n++;
            @(negedge i_clk);
        end
        if (n >= 1000)
        begin
            num_errors++;
            close_out;
        end
        check({o_pkt_vc, o_pkt_dt}, {2'h1, dt});
        check({o_pkt_short, o_pkt_sof, o_pkt_eof}, fl);
        if (!fl[2]) check(o_pkt_data, d);
        @(posedge i_clk) #1;
    endtask
    // per: expected line spacing in ns with a free-running sink, 0 to skip
    task automatic frame(input bit fx, input int per);
        int t = 0;
        beat(6'h00, 3'h7, 8'h00);
        for (int l = 0; l < 2; l++)
            for (int k = 0; k < 5; k++)
            begin
                beat(6'h2a, {1'b0, k == 0, k == 4}, fx ? fill[k % 3] : fill[k >= 2]);
                if (k == 0 && l == 1 && per > 0)
                    check(($time - t > per - 100) && ($time - t < per + 100), 1'b1);
                if (k == 0)
                    t = $time;
            end
        beat(6'h01, 3'h7, 8'h00);
    endtask
    initial
    begin
        logic [7:0] d;
        repeat (8) @(posedge i_clk);
        #1 i_nrst = 1;
        for (int a = 0; a < 20; a++)
        begin
            rd(a[4:0], d);
            check(d, rv[a]);
        end
        check(o_busy, 1'b0);
        for (int a = 4; a < 16; a++) wr(a[4:0], cv[a]);
        wr(5'h03, 8'h6a);
        wr(5'h02, 8'h13);
        rd(5'h03, d);
        check(d, 8'h6a);
        wr(5'h01, 8'h01);
        frame(0, 0);
        slow = 0;
        frame(0, 2560);
        wr(5'h01, 8'h00);
        repeat (400) @(posedge i_clk);
        check({o_busy, o_pkt_valid}, 2'h0);
        wr(5'h02, 8'h93);
        rate = 2'h0;
        wr(5'h01, 8'h01);
        frame(1, 5120);
        rate = 2'h2;
        frame(1, 3413);
        close_out;
    end
endmodule // tb
